// *** pkg/timer5_consts.svh ***
/*
  Offsets, field positions, reset values and mode codes of the
  force-compare, counter and compare-value registers.
  Assumes byte addressing on the CPU data bus, 12-bit addresses.
*/
`ifndef TIMER5_CONSTS_SVH
`define TIMER5_CONSTS_SVH

// Register offsets
`define OFS_FORCE_CTRL   12'h0122
`define OFS_COUNT_LOW    12'h0124
`define OFS_COUNT_HIGH   12'h0125
`define OFS_CMP_A_LOW    12'h0128
`define OFS_CMP_A_HIGH   12'h0129
`define OFS_CMP_B_LOW    12'h012A
`define OFS_CMP_B_HIGH   12'h012B

// Force control bit positions
`define BIT_FORCE_A      7
`define BIT_FORCE_B      6
`define BIT_FORCE_C      5

// Reset values
`define RST_BYTE         8'h00
`define RST_WORD         16'h0000

// Waveform and compare output mode codes of interest
`define WGM_NORMAL       4'h0
`define WGM_CTC_A        4'h4
`define WGM_CTC_A_ALT    4'hC
`define COM_NORMAL       2'h0

`endif

// *** pkg/timer5_pkg.sv ***
/*
  Shared types of the timer register slice.
  Assumes the constants header is included by the design files.
*/
package timer5_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;

  // Coarse class of a waveform mode
  typedef enum logic [1:0] {
    WAVE_NORMAL,
    WAVE_CTC,
    WAVE_PWM
  } wave_kind_t;

endpackage : timer5_pkg

// *** pkg/compare_if.sv ***
/*
  Carrier between the register slice and one compare channel.
  Assumes both ends share the timer's single clock.
*/
`timescale 1ns/10ps
interface compare_if;
  import timer5_pkg::*;

  logic  clkEn;
  logic  tick;
  word_t countVal;
  word_t cmpVal;
  logic  blockMatch;
  logic  flagClr;
  logic  hit;
  logic  flag;

  modport chan (
    input  clkEn, tick, countVal, cmpVal, blockMatch, flagClr,
    output hit, flag
  );
  modport ctrl (
    output clkEn, tick, countVal, cmpVal, blockMatch, flagClr,
    input  hit, flag
  );
endinterface : compare_if

// *** hw/compare_channel.sv ***
/*
  One compare channel: equality against the counter and the sticky
  match flag. Assumes tick is a one-cycle timer-clock enable.
*/
`timescale 1ns/10ps
module compare_channel
  import timer5_pkg::*;
(
  input wire logic    clock,
  input wire logic    rst_n,
  compare_if.chan     cmp
);

  logic flag_r;
  logic flag_nxt;

  //////////////////////////////////////////////////////////////////////
  // Real match only; a blocked tick after a counter write never hits
  assign cmp.hit  = cmp.tick && !cmp.blockMatch && (cmp.countVal == cmp.cmpVal);
  // Set wins over clear so a match in the clearing cycle is kept
  assign flag_nxt = cmp.hit ? 1'b1 : (cmp.flagClr ? 1'b0 : flag_r);
  assign cmp.flag = flag_r;

  // Flag lands one cycle after the equal tick
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (cmp.clkEn) begin
      flag_r <= flag_nxt;
    end
  end

endmodule : compare_channel

// *** hw/timer5_force_count_compare_regs.sv ***
/*
  Register slice of a pinless 16-bit timer: force-compare strobes,
  counter and compare values A and B behind a shared high-byte latch.
  Assumes a synchronous CPU byte bus and a timer tick on the same clock.
*/
`timescale 1ns/10ps
`include "timer5_consts.svh"

module timer5_force_count_compare_regs
  import timer5_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  input  wire logic       timerTick,
  input  wire logic [11:0] busAddr,
  input  wire logic       busWrEn,
  input  wire logic       busRdEn,
  input  wire logic [7:0] busWrData,
  output logic      [7:0] busRdData,
  input  wire logic [3:0] waveform_mode_sel,
  input  wire logic [1:0] cmp_out_mode_a,
  input  wire logic [1:0] cmp_out_mode_b,
  input  wire logic [1:0] cmp_out_mode_c,
  input  wire logic       matchIntEnA,
  input  wire logic       matchIntEnB,
  input  wire logic       matchClrA,
  input  wire logic       matchClrB,
  output logic      [15:0] count_value,
  output logic            matchFlagA,
  output logic            matchFlagB,
  output logic            matchIrqA,
  output logic            matchIrqB,
  output logic            forcedMatchA,
  output logic            forcedMatchB,
  output logic            forcedMatchC
);

  // Classify a waveform code; reserved 0xD is treated as no-force
  function automatic wave_kind_t waveKind(input logic [3:0] code);
    wave_kind_t kind;
    kind = WAVE_PWM;
    case (code)
      `WGM_NORMAL:    kind = WAVE_NORMAL;
      `WGM_CTC_A:     kind = WAVE_CTC;
      `WGM_CTC_A_ALT: kind = WAVE_CTC;
      default:        kind = WAVE_PWM;
    endcase
    return kind;
  endfunction : waveKind

  // Forced match only acts when the output mode is the defined one
  function automatic logic forceEffect(input logic strobe, input logic [1:0] mode);
    return strobe && (mode == `COM_NORMAL);
  endfunction : forceEffect

  word_t      count_r,   count_nxt;
  word_t      cmpA_r,    cmpB_r;
  byte_t      latch_r,   latch_nxt;
  logic       block_r;
  logic [7:0] rdData_r;
  logic       irqA_r, irqB_r;
  logic       frcA_r, frcB_r, frcC_r;

  compare_if  chanA ();
  compare_if  chanB ();

  //////////////////////////////////////////////////////////////////////
  // Address decode
  wire wrForce   = busWrEn && (busAddr == `OFS_FORCE_CTRL);
  wire wrCntLow  = busWrEn && (busAddr == `OFS_COUNT_LOW);
  wire wrCntHigh = busWrEn && (busAddr == `OFS_COUNT_HIGH);
  wire wrALow    = busWrEn && (busAddr == `OFS_CMP_A_LOW);
  wire wrAHigh   = busWrEn && (busAddr == `OFS_CMP_A_HIGH);
  wire wrBLow    = busWrEn && (busAddr == `OFS_CMP_B_LOW);
  wire wrBHigh   = busWrEn && (busAddr == `OFS_CMP_B_HIGH);
  wire rdCntLow  = busRdEn && (busAddr == `OFS_COUNT_LOW);
  wire wrAnyHigh = wrCntHigh || wrAHigh || wrBHigh;

  wire wave_kind_t kindNow = waveKind(waveform_mode_sel);
  wire             nonPwm  = (kindNow != WAVE_PWM);
  wire             ctcA    = (kindNow == WAVE_CTC);

  //////////////////////////////////////////////////////////////////////
  // Force strobes: decoded on the write, never stored in the register
  wire forceA = wrForce && nonPwm && busWrData[`BIT_FORCE_A];
  wire forceB = wrForce && nonPwm && busWrData[`BIT_FORCE_B];
  wire forceC = wrForce && nonPwm && busWrData[`BIT_FORCE_C];

  //////////////////////////////////////////////////////////////////////
  // Shared latch: high-byte writes park here, low-count read fills it
  assign latch_nxt = wrAnyHigh ? busWrData :
                     (rdCntLow ? count_r[15:8] : latch_r);

  // Counter: CPU write first, then clear on A in CLEAR_ON_MATCH_MODE, else count up.
  // The forced match is not part of hit, so it never clears here.
  assign count_nxt = wrCntLow  ? {latch_r, busWrData} :
                     !timerTick ? count_r :
                     (chanA.hit && ctcA) ? `RST_WORD :
                     count_r + 16'h0001;

  //////////////////////////////////////////////////////////////////////
  // Read mux; force bits and reserved bits always read zero
  wire byte_t rdMux =
    (busAddr == `OFS_FORCE_CTRL) ? `RST_BYTE :
    (busAddr == `OFS_COUNT_LOW)  ? count_r[7:0] :
    (busAddr == `OFS_COUNT_HIGH) ? latch_r :
    (busAddr == `OFS_CMP_A_LOW)  ? cmpA_r[7:0] :
    (busAddr == `OFS_CMP_A_HIGH) ? cmpA_r[15:8] :
    (busAddr == `OFS_CMP_B_LOW)  ? cmpB_r[7:0] :
    (busAddr == `OFS_CMP_B_HIGH) ? cmpB_r[15:8] :
    `RST_BYTE;

  //////////////////////////////////////////////////////////////////////
  // Channel hookups
  assign chanA.clkEn      = clkEn;
  assign chanA.tick       = timerTick;
  assign chanA.countVal   = count_r;
  assign chanA.cmpVal     = cmpA_r;
  assign chanA.blockMatch = block_r;
  assign chanA.flagClr    = matchClrA;
  assign chanB.clkEn      = clkEn;
  assign chanB.tick       = timerTick;
  assign chanB.countVal   = count_r;
  assign chanB.cmpVal     = cmpB_r;
  assign chanB.blockMatch = block_r;
  assign chanB.flagClr    = matchClrB;

  compare_channel uChanA (
    .clock (clock),
    .rst_n (rst_n),
    .cmp   (chanA.chan)
  );

  compare_channel uChanB (
    .clock (clock),
    .rst_n (rst_n),
    .cmp   (chanB.chan)
  );

  //////////////////////////////////////////////////////////////////////
  // Counter, latch and the one-tick match block after a counter write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= `RST_WORD;
      latch_r <= `RST_BYTE;
      block_r <= 1'b0;
    end else if (clkEn) begin
      count_r <= count_nxt;
      latch_r <= latch_nxt;
      block_r <= wrCntLow ? 1'b1 : (timerTick ? 1'b0 : block_r);
    end
  end

  // Compare values commit both bytes on the low write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cmpA_r <= `RST_WORD;
      cmpB_r <= `RST_WORD;
    end else if (clkEn) begin
      if (wrALow) cmpA_r <= {latch_r, busWrData};
      if (wrBLow) cmpB_r <= {latch_r, busWrData};
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r <= `RST_BYTE;
    end else if (clkEn && busRdEn) begin
      rdData_r <= rdMux;
    end
  end

  // Event outputs: real matches feed interrupts, forced ones only pulse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irqA_r <= 1'b0;
      irqB_r <= 1'b0;
      frcA_r <= 1'b0;
      frcB_r <= 1'b0;
      frcC_r <= 1'b0;
    end else if (clkEn) begin
      irqA_r <= chanA.flag && matchIntEnA;
      irqB_r <= chanB.flag && matchIntEnB;
      frcA_r <= forceEffect(forceA, cmp_out_mode_a);
      frcB_r <= forceEffect(forceB, cmp_out_mode_b);
      frcC_r <= forceEffect(forceC, cmp_out_mode_c);
    end
  end

  assign busRdData    = rdData_r;
  assign count_value  = count_r;
  assign matchFlagA   = chanA.flag;
  assign matchFlagB   = chanB.flag;
  assign matchIrqA    = irqA_r;
  assign matchIrqB    = irqB_r;
  assign forcedMatchA = frcA_r;
  assign forcedMatchB = frcB_r;
  assign forcedMatchC = frcC_r;

endmodule : timer5_force_count_compare_regs

// *** sim/timer5_props.sv ***
/*
  Concurrent checks of the force, count and compare slice.
  Assumes one clock domain and the top module's port names.
*/
`timescale 1ns/10ps
`include "timer5_consts.svh"
module timer5_props (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        clkEn,
  input wire logic        timerTick,
  input wire logic [11:0] busAddr,
  input wire logic        busWrEn,
  input wire logic        busRdEn,
  input wire logic [7:0]  busWrData,
  input wire logic [7:0]  busRdData,
  input wire logic [3:0]  waveform_mode_sel,
  input wire logic [1:0]  cmp_out_mode_a,
  input wire logic [1:0]  cmp_out_mode_b,
  input wire logic        matchIntEnA,
  input wire logic        matchClrA,
  input wire logic [15:0] count_value,
  input wire logic        matchFlagA,
  input wire logic        matchIrqA,
  input wire logic        forcedMatchA,
  input wire logic        forcedMatchB
);
  ////////////////////////////////////////////////
  // Decoded bus events
  wire fWr = clkEn && busWrEn && busAddr == `OFS_FORCE_CTRL;
  wire cWr = clkEn && busWrEn && busAddr == `OFS_COUNT_LOW;
  wire modeOk = waveform_mode_sel inside {4'h0, 4'h4, 4'hC};
  wire clear_on_match_mode = waveform_mode_sel inside {4'h4, 4'hC};

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Pending block: armed by a counter write, spent by the next tick, however late
  logic blkPend;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      blkPend <= 1'b0;
    end else if (clkEn) begin
      blkPend <= cWr ? 1'b1 : (timerTick ? 1'b0 : blkPend);
    end
  end

  ////////////////////////////////////////////////
  force_a_cause_a:
    assert property (forcedMatchA && $past(clkEn) |-> $past(fWr && busWrData[7] && modeOk && cmp_out_mode_a == 2'h0))
    else $error("forced A without cause");
  force_b_cause_a:
    assert property (forcedMatchB && $past(clkEn) |-> $past(fWr && busWrData[6] && modeOk && cmp_out_mode_b == 2'h0))
    else $error("forced B without cause");
  force_a_pulse_a:
    assert property (fWr && busWrData[7] && modeOk && cmp_out_mode_a == 2'h0 |=> forcedMatchA)
    else $error("forced A missing");
  force_no_flag_a:
    assert property (fWr && !timerTick && !matchFlagA |=> !matchFlagA)
    else $error("force set flag");
  force_reads_zero_a:
    assert property (clkEn && busRdEn && busAddr == `OFS_FORCE_CTRL |=> busRdData == 8'h00)
    else $error("force reg read nonzero");
  write_blocks_tick_a:
    assert property (blkPend && clkEn && timerTick && !matchFlagA |=> !matchFlagA)
    else $error("match after counter write");
  flag_needs_tick_a:
    assert property ($rose(matchFlagA) |-> $past(timerTick && clkEn))
    else $error("flag rose without tick");
  flag_clear_a:
    assert property (matchClrA && clkEn && !timerTick |=> !matchFlagA)
    else $error("flag not cleared");
  irq_follows_a:
    assert property ($past(clkEn) |-> matchIrqA == $past(matchFlagA && matchIntEnA))
    else $error("irq not flag and enable");
  ctc_clears_a:
    assert property ($rose(matchFlagA) && $past(clear_on_match_mode) && !$past(busWrEn) |-> count_value == 16'h0000)
    else $error("no clear on A match");

  // Main scenarios reached
  cover property (forcedMatchA && forcedMatchB);
  cover property ($rose(matchIrqA));
  cover property ($rose(matchFlagA) && clear_on_match_mode);
endmodule : timer5_props

bind timer5_force_count_compare_regs timer5_props props_u (.*);

// *** sim/timer5_force_count_compare_regs_tb_top.sv ***
/*
  Directed bench for the force, count and compare slice.
  Assumes bus strobes taken on rising edges; drives on falling edges.
*/
`timescale 1ns/10ps
`include "timer5_consts.svh"
module timer5_force_count_compare_regs_tb_top;
  import timer5_pkg::*;
  logic        clock = 0, rst_n = 0, clkEn = 1, timerTick = 0;
  logic        busWrEn = 0, busRdEn = 0, matchIntEnA = 0, matchIntEnB = 0;
  logic        matchClrA = 0, matchClrB = 0, fA, fB, fC, flA, flB, irA, irB;
  logic [11:0] busAddr = 0;
  byte_t       busWrData = 0, busRdData;
  logic [3:0]  wave = 0;
  logic [1:0]  comA = 0, comB = 0, comC = 0;
  word_t       count;
  int          failures = 0, checks = 0, cycles = 0;

  timer5_force_count_compare_regs dut_u (
    .clock, .rst_n, .clkEn, .timerTick, .busAddr, .busWrEn, .busRdEn, .busWrData, .busRdData,
    .waveform_mode_sel(wave), .cmp_out_mode_a(comA), .cmp_out_mode_b(comB), .cmp_out_mode_c(comC),
    .matchIntEnA, .matchIntEnB, .matchClrA, .matchClrB, .count_value(count), .matchFlagA(flA),
    .matchFlagB(flB), .matchIrqA(irA), .matchIrqB(irB), .forcedMatchA(fA), .forcedMatchB(fB),
    .forcedMatchC(fC));

  // Clock and hang guard, ceiling far above the under two hundred cycles needed
  initial forever #12.5 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      report_and_stop;
    end
  end

  ////////////////////////////////////////////////
  // Wide enough for flag bits packed beside the 16-bit count
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  // One-cycle strobes; a gap cycle keeps drivers from double assignment
  task automatic wr(logic [11:0] a, byte_t d);
    @(negedge clock);
    {busAddr, busWrData, busWrEn} = {a, d, 1'b1};
    @(negedge clock);
    busWrEn = 0;
  endtask : wr
  task automatic rd(logic [11:0] a, byte_t e, string n);
    @(negedge clock);
    {busAddr, busRdEn} = {a, 1'b1};
    @(negedge clock);
    busRdEn = 0;
    chk(n, busRdData, e);
  endtask : rd
  // High byte first, low write commits both
  task automatic wr16(logic [11:0] hi, word_t v);
    wr(hi, v[15:8]);
    wr(hi - 12'h001, v[7:0]);
  endtask : wr16
  task automatic tk;
    @(negedge clock);
    timerTick = 1;
    @(negedge clock);
    timerTick = 0;
  endtask : tk
  task automatic clr;
    @(negedge clock);
    {matchClrA, matchClrB} = 2'b11;
    @(negedge clock);
    {matchClrA, matchClrB} = 2'b00;
  endtask : clr

  ////////////////////////////////////////////////
  task automatic reset_values;
    logic [11:0] a[8] = '{12'h122, 12'h124, 12'h125, 12'h128, 12'h129, 12'h12A, 12'h12B, 12'h130};
    foreach (a[i]) rd(a[i], 8'h00, "reset read");
  endtask : reset_values
  task automatic latch_pairing;
    wr16(`OFS_CMP_A_HIGH, 16'h1234);
    rd(`OFS_CMP_A_LOW, 8'h34, "cmp a low");
    rd(`OFS_CMP_A_HIGH, 8'h12, "cmp a high");
    wr(`OFS_COUNT_HIGH, 8'h56);
    wr(`OFS_CMP_B_LOW, 8'h78);
    rd(`OFS_CMP_B_HIGH, 8'h56, "shared latch");
    chk("count untouched", count, 16'h0000);
  endtask : latch_pairing
  task automatic count_access;
    wr16(`OFS_COUNT_HIGH, 16'h01FE);
    chk("count write", count, 16'h01FE);
    tk;
    rd(`OFS_COUNT_LOW, 8'hFF, "count low");
    tk;
    rd(`OFS_COUNT_HIGH, 8'h01, "latched high");
    chk("count run", count, 16'h0200);
  endtask : count_access
  task automatic match_block_irq;
    {matchIntEnA, matchIntEnB} = 2'b10;
    wr16(`OFS_CMP_A_HIGH, 16'h0005);
    wr16(`OFS_CMP_B_HIGH, 16'h0006);
    wr16(`OFS_COUNT_HIGH, 16'h0005);
    tk;
    chk("blocked flag a", flA, 1'b0);
    tk;
    chk("flag b", flB, 1'b1);
    @(negedge clock);
    chk("irq b off", irB, 1'b0);
    wr16(`OFS_COUNT_HIGH, 16'h0004);
    tk;
    tk;
    chk("flag a", flA, 1'b1);
    @(negedge clock);
    chk("irq a", irA, 1'b1);
    clr;
    chk("flags cleared", {flA, flB}, 2'b00);
  endtask : match_block_irq
  task automatic ctc_modes;
    logic [3:0] m[2] = '{4'h4, 4'hC};
    foreach (m[i]) begin
      wave = m[i];
      wr16(`OFS_COUNT_HIGH, 16'h0003);
      repeat (3) tk;
      chk("ctc clear", count, 16'h0000);
    end
    clr;
  endtask : ctc_modes
  task automatic force_modes;
    logic ok;
    wr16(`OFS_COUNT_HIGH, 16'h0100);
    for (int i = 0; i < 16; i++) begin
      wave = i[3:0];
      ok = wave inside {4'h0, 4'h4, 4'hC};
      wr(`OFS_FORCE_CTRL, 8'hE0);
      chk("forced abc", {fA, fB, fC}, {3{ok}});
    end
    chk("force side effects", {flA, flB, irA, count}, {3'b000, 16'h0100});
    {wave, comA, comB, comC} = {4'h0, 2'h1, 2'h2, 2'h3};
    wr(`OFS_FORCE_CTRL, 8'hE0);
    chk("forced reserved com", {fA, fB, fC}, 3'b000);
    {comA, comB, comC} = 6'h00;
    wr(`OFS_FORCE_CTRL, 8'hFF);
    rd(`OFS_FORCE_CTRL, 8'h00, "force reg");
  endtask : force_modes
  // Frozen enable ignores ticks and writes; then a short mid-run reset
  task automatic freeze_and_reset;
    wr16(`OFS_COUNT_HIGH, 16'h0010);
    @(negedge clock);
    clkEn = 0;
    tk;
    wr(`OFS_COUNT_HIGH, 8'hAA);
    wr(`OFS_FORCE_CTRL, 8'h80);
    chk("frozen count", count, 16'h0010);
    chk("frozen force", fA, 1'b0);
    @(negedge clock);
    clkEn = 1;
    wr(`OFS_COUNT_LOW, 8'h22);
    chk("latch kept while frozen", count, 16'h0022);
    @(negedge clock);
    rst_n = 0;
    @(negedge clock);
    rst_n = 1;
    chk("count after reset", count, 16'h0000);
    rd(`OFS_CMP_A_LOW, 8'h00, "cmp a after reset");
  endtask : freeze_and_reset

  task automatic report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  // Main sequence after sixteen reset cycles
  initial begin
    repeat (16) @(negedge clock);
    rst_n = 1;
    reset_values;
    latch_pairing;
    count_access;
    match_block_irq;
    ctc_modes;
    force_modes;
    freeze_and_reset;
    report_and_stop;
  end
endmodule : timer5_force_count_compare_regs_tb_top
